// *** design/sdps_pkg.sv ***
// Purpose: Constants for the serial and decoder pin sharing block
// Assumes: One reference clock domain plus the SPI link clock
// Notes:   Pin indices select bits of the shared port pin vectors
//
// Summary of operation
// - Master-in pin: master input, slave output
// - Unselected slave releases master-in pin
// - Master-out pin: master output, slave input
// - Master-out data ahead of sampling edge
// - Clock pin: master drives, slave receives
// - Slave select pin always an input in SPI use
// - Each shared pin usable as port bit
// - SPI pins come up as SPI functions
// - Serial transmit pins default to transmit
// - Serial receive pins default to receive
// - Decoder and timer pins are inputs in reset

package sdps_pkg;

    // =====================================================================
    // Shared port pin indices
    localparam int NPORT = 8;
    localparam int NDEC  = 8;
    localparam int PIN_MISO = 0;   // port_e_bit_six
    localparam int PIN_MOSI = 1;   // port_e_bit_five
    localparam int PIN_SCLK = 2;   // port_e_bit_four
    localparam int PIN_SS   = 3;   // port_e_bit_seven
    localparam int PIN_TX0  = 4;   // port_e_bit_zero, serial0_tx_pin
    localparam int PIN_RX0  = 5;   // port_e_bit_one, serial0_rx_pin
    localparam int PIN_TX1  = 6;   // port_d_bit_six, serial1_tx_pin
    localparam int PIN_RX1  = 7;   // port_d_bit_seven, serial1_rx_pin

    // =====================================================================
    // Reset values
    localparam logic [7:0] FSEL_RST   = 8'hff;   // 1 = peripheral function
    localparam logic [7:0] DIR_RST    = 8'h00;   // 1 = port output
    localparam logic [7:0] OE_N_RST   = 8'hff;   // All released
    localparam logic [7:0] OUT_RST    = 8'h00;
    localparam logic [7:0] BYTE_RST   = 8'h00;
    // Select idles high; a low reset level would fake a selection
    localparam logic [7:0] PIN_SYNC_RST = 8'h08;

    // =====================================================================
    // Link framing
    localparam int         LINK_BITS  = 8;
    localparam logic [2:0] LINK_LAST  = 3'h7;
    localparam logic [2:0] LINK_FIRST = 3'h0;

endpackage

// *** design/sdps_sync.sv ***
// Purpose: Two-stage synchroniser for a vector of asynchronous levels
// Assumes: Each bit is an independent level
// Notes:   Only the second stage is visible to the user

`timescale 1ns/1ps
`default_nettype none

module sdps_sync #(
    parameter int           W   = 1,
    // Per-bit reset level, matched to each pin's idle level
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sdps_sync_t;

    sdps_sync_t q;
    sdps_sync_t d;

    always_comb
    begin
        d    = q;
        d.s1 = async_i;
        d.s2 = q.s1;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q.s1 <= RST;
            q.s2 <= RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign sync_o = q.s2;

endmodule

`default_nettype wire

// *** design/sdps_link_rx.sv ***
// Purpose: Slave-side capture of master-out bits on the link clock
// Assumes: Mode 0 framing, bits sampled on the rising link edge
// Notes:   A completed byte is announced by a toggle for the ref domain

`timescale 1ns/1ps
`default_nettype none

module sdps_link_rx (
    input  wire logic       spi_link_clk,
    input  wire logic       nrst,
    input  wire logic       ss_n_pin,
    input  wire logic       mosi_pin,
    output logic      [7:0] byte_o,
    output logic            tgl_o
);

    typedef struct packed {
        logic [2:0] cnt;
    } sdps_frame_t;

    typedef struct packed {
        logic [7:0] shf;
        logic [7:0] hold;
        logic       tgl;
    } sdps_link_t;

    sdps_frame_t fq;
    sdps_frame_t fd;
    sdps_link_t  q;
    sdps_link_t  d;
    logic        frame_rst_n;

    // Link clock stops between frames, so deselect ends the frame itself
    assign frame_rst_n = nrst & ~ss_n_pin;

    always_comb
    begin
        fd     = fq;
        d      = q;
        fd.cnt = fq.cnt + 3'h1;
        d.shf  = {q.shf[6:0], mosi_pin};
        if (fq.cnt == sdps_pkg::LINK_LAST)
        begin
            d.hold = {q.shf[6:0], mosi_pin};
            d.tgl  = ~q.tgl;
        end
    end

    always_ff @(posedge spi_link_clk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            fq.cnt <= sdps_pkg::LINK_FIRST;
        end
        else
        begin
            fq <= fd;
        end
    end

    // Toggle survives deselect; clearing it would fake a byte event
    always_ff @(posedge spi_link_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign byte_o = q.hold;
    assign tgl_o  = q.tgl;

endmodule

`default_nettype wire

// *** design/sdps_pin_mux.sv ***
// Purpose: Shared pin multiplexer for SPI, two serial channels, decoders
// Assumes: Peripheral cores run on ref_clk; pads resolved by the bench
// Notes:   Output enables are active low; all pad outputs are registered

`timescale 1ns/1ps
`default_nettype none

module sdps_pin_mux (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       spi_link_clk,
    // Configuration from the local controller
    input  wire logic       cfg_wr,
    input  wire logic [7:0] cfg_fsel,
    input  wire logic [7:0] cfg_dir,
    input  wire logic [7:0] gpio_out,
    output logic      [7:0] gpio_in,
    output logic      [7:0] cfg_fsel_q,
    output logic      [7:0] cfg_dir_q,
    // SPI core side
    input  wire logic       spi_master,
    input  wire logic       spi_frame,
    input  wire logic       spi_sclk_core,
    input  wire logic       spi_mosi_core,
    input  wire logic       spi_miso_core,
    output logic            spi_miso_in,
    output logic            spi_mosi_in,
    output logic            spi_sclk_in,
    output logic            spi_ss_n_in,
    output logic      [7:0] slv_byte,
    output logic            slv_byte_vld,
    // Serial channel cores
    input  wire logic       sci0_tx_core,
    input  wire logic       sci1_tx_core,
    output logic            sci0_rx,
    output logic            sci1_rx,
    // Timer channels and decoders
    input  wire logic [7:0] tmr_out,
    input  wire logic [7:0] tmr_oe,
    output logic      [7:0] tmr_in,
    output logic            dec0_phase_a,
    output logic            dec0_phase_b,
    output logic            dec0_index_in,
    output logic            dec0_home_in,
    output logic            dec1_phase_a,
    output logic            dec1_phase_b,
    output logic            dec1_index_in,
    output logic            dec1_home_in,
    // Shared port pins
    input  wire logic [7:0] pad_i,
    output logic      [7:0] pad_o,
    output logic      [7:0] pad_oe_n,
    // Decoder and timer pins
    input  wire logic [7:0] dec_pad_i,
    output logic      [7:0] dec_pad_o,
    output logic      [7:0] dec_pad_oe_n
);

    // =====================================================================
    // State
    typedef struct packed {
        logic [7:0] fsel;
        logic [7:0] dir;
        logic [7:0] pad_o;
        logic [7:0] pad_oe_n;
        logic [7:0] dec_o;
        logic [7:0] dec_oe_n;
        logic       mosi_hold;
        logic       sclk_prev;
        logic       tgl_prev;
        logic [7:0] rx_byte;
        logic       rx_vld;
    } sdps_state_t;

    sdps_state_t q;
    sdps_state_t d;

    logic [16:0] sync_s;
    logic [7:0]  pin_s;
    logic [7:0]  link_byte;
    logic        link_tgl;
    logic        ss_n_s;
    logic        sclk_fall;

    // =====================================================================
    // Input synchronisation and slave link capture
    sdps_sync #(
        .W   (17),
        .RST ({9'h000, sdps_pkg::PIN_SYNC_RST})
    ) u_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .async_i ({link_tgl, dec_pad_i, pad_i}),
        .sync_o  (sync_s)
    );

    sdps_link_rx u_link (
        .spi_link_clk (spi_link_clk),
        .nrst         (nrst),
        .ss_n_pin     (pad_i[sdps_pkg::PIN_SS]),
        .mosi_pin     (pad_i[sdps_pkg::PIN_MOSI]),
        .byte_o       (link_byte),
        .tgl_o        (link_tgl)
    );

    assign pin_s     = sync_s[7:0];
    assign ss_n_s    = pin_s[sdps_pkg::PIN_SS];
    assign sclk_fall = q.sclk_prev & ~spi_sclk_core;

    // =====================================================================
    // Next state
    always_comb
    begin
        d           = q;
        d.sclk_prev = spi_sclk_core;
        d.tgl_prev  = sync_s[16];
        d.rx_vld    = 1'b0;

        if (cfg_wr)
        begin
            d.fsel = cfg_fsel;
            d.dir  = cfg_dir;
        end

        // Master-out bit moves only as the clock falls inside a frame
        if (!spi_frame || sclk_fall)
        begin
            d.mosi_hold = spi_mosi_core;
        end

        for (int i = 0; i < sdps_pkg::NPORT; i++)
        begin
            d.pad_o[i]    = gpio_out[i];
            d.pad_oe_n[i] = ~q.dir[i];
        end

        if (q.fsel[sdps_pkg::PIN_MISO])
        begin
            d.pad_o[sdps_pkg::PIN_MISO]    = spi_miso_core;
            // Master listens; slave talks only while selected
            d.pad_oe_n[sdps_pkg::PIN_MISO] = spi_master | ss_n_s;
        end
        if (q.fsel[sdps_pkg::PIN_MOSI])
        begin
            d.pad_o[sdps_pkg::PIN_MOSI]    = d.mosi_hold;
            d.pad_oe_n[sdps_pkg::PIN_MOSI] = ~spi_master;
        end
        if (q.fsel[sdps_pkg::PIN_SCLK])
        begin
            d.pad_o[sdps_pkg::PIN_SCLK]    = spi_sclk_core;
            d.pad_oe_n[sdps_pkg::PIN_SCLK] = ~spi_master;
        end
        if (q.fsel[sdps_pkg::PIN_SS])
        begin
            d.pad_o[sdps_pkg::PIN_SS]      = 1'b0;
            d.pad_oe_n[sdps_pkg::PIN_SS]   = 1'b1;
        end
        if (q.fsel[sdps_pkg::PIN_TX0])
        begin
            d.pad_o[sdps_pkg::PIN_TX0]     = sci0_tx_core;
            d.pad_oe_n[sdps_pkg::PIN_TX0]  = 1'b0;
        end
        if (q.fsel[sdps_pkg::PIN_TX1])
        begin
            d.pad_o[sdps_pkg::PIN_TX1]     = sci1_tx_core;
            d.pad_oe_n[sdps_pkg::PIN_TX1]  = 1'b0;
        end
        if (q.fsel[sdps_pkg::PIN_RX0])
        begin
            d.pad_o[sdps_pkg::PIN_RX0]     = 1'b0;
            d.pad_oe_n[sdps_pkg::PIN_RX0]  = 1'b1;
        end
        if (q.fsel[sdps_pkg::PIN_RX1])
        begin
            d.pad_o[sdps_pkg::PIN_RX1]     = 1'b0;
            d.pad_oe_n[sdps_pkg::PIN_RX1]  = 1'b1;
        end

        // Timer channels drive only on request; decoders just listen
        d.dec_o    = tmr_out;
        d.dec_oe_n = ~tmr_oe;

        // Byte from the link; data settled long before the toggle lands
        if (sync_s[16] != q.tgl_prev)
        begin
            if (!spi_master && q.fsel[sdps_pkg::PIN_MOSI])
            begin
                d.rx_byte = link_byte;
                d.rx_vld  = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q.fsel      <= sdps_pkg::FSEL_RST;
            q.dir       <= sdps_pkg::DIR_RST;
            q.pad_o     <= sdps_pkg::OUT_RST;
            q.pad_oe_n  <= sdps_pkg::OE_N_RST;
            q.dec_o     <= sdps_pkg::OUT_RST;
            q.dec_oe_n  <= sdps_pkg::OE_N_RST;
            q.mosi_hold <= 1'b0;
            q.sclk_prev <= 1'b0;
            q.tgl_prev  <= 1'b0;
            q.rx_byte   <= sdps_pkg::BYTE_RST;
            q.rx_vld    <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    // =====================================================================
    // Outputs
    assign pad_o        = q.pad_o;
    assign pad_oe_n     = q.pad_oe_n;
    assign dec_pad_o    = q.dec_o;
    assign dec_pad_oe_n = q.dec_oe_n;
    assign cfg_fsel_q   = q.fsel;
    assign cfg_dir_q    = q.dir;
    assign gpio_in      = pin_s;
    assign slv_byte     = q.rx_byte;
    assign slv_byte_vld = q.rx_vld;
    assign spi_miso_in  = pin_s[sdps_pkg::PIN_MISO];
    assign spi_mosi_in  = pin_s[sdps_pkg::PIN_MOSI];
    assign spi_sclk_in  = pin_s[sdps_pkg::PIN_SCLK];
    // Port use of the select pin must not select the core
    assign spi_ss_n_in  = ss_n_s | ~q.fsel[sdps_pkg::PIN_SS];
    assign sci0_rx      = pin_s[sdps_pkg::PIN_RX0] | ~q.fsel[sdps_pkg::PIN_RX0];
    assign sci1_rx      = pin_s[sdps_pkg::PIN_RX1] | ~q.fsel[sdps_pkg::PIN_RX1];
    assign tmr_in        = sync_s[15:8];
    assign dec0_phase_a  = sync_s[8];
    assign dec0_phase_b  = sync_s[9];
    assign dec0_index_in = sync_s[10];
    assign dec0_home_in  = sync_s[11];
    assign dec1_phase_a  = sync_s[12];
    assign dec1_phase_b  = sync_s[13];
    assign dec1_index_in = sync_s[14];
    assign dec1_home_in  = sync_s[15];

    // =====================================================================
    // Checks
    logic cfg_seen_q;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_seen_q <= 1'b0;
        end
        else if (cfg_wr)
        begin
            cfg_seen_q <= 1'b1;
        end
    end

    AST_MISO_MASTER_IN: assert property (@(posedge ref_clk) disable iff (!nrst)
        (q.fsel[0] && spi_master) |=> pad_oe_n[0])
        else $error("Master-in pin driven while master");

    AST_MISO_SLAVE_HIZ: assert property (@(posedge ref_clk) disable iff (!nrst)
        (q.fsel[0] && !spi_master) |=> (pad_oe_n[0] == $past(ss_n_s)))
        else $error("Slave master-in drive does not follow select");

    AST_MOSI_DIR: assert property (@(posedge ref_clk) disable iff (!nrst)
        q.fsel[1] |=> (pad_oe_n[1] == !$past(spi_master)))
        else $error("Master-out pin direction wrong for role");

    AST_MOSI_AHEAD: assert property (@(posedge ref_clk) disable iff (!nrst)
        (q.fsel[1] && q.fsel[2] && spi_master && spi_frame && !sclk_fall)
        |=> ($stable(pad_o[1]) && !$fell(pad_o[2])))
        else $error("Master-out bit moved away from clock fall");

    AST_SCLK_ROLE: assert property (@(posedge ref_clk) disable iff (!nrst)
        (q.fsel[2] && spi_master) |=> (!pad_oe_n[2] && pad_o[2] == $past(spi_sclk_core)))
        else $error("Clock pin not driven from core in master role");

    AST_SS_INPUT: assert property (@(posedge ref_clk) disable iff (!nrst)
        q.fsel[3] |=> pad_oe_n[3])
        else $error("Select pin driven in peripheral use");

    AST_PORT_BIT: assert property (@(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> (((pad_oe_n ^ ~$past(q.dir)) & ~$past(q.fsel)) == 8'h00
                 && ((pad_o ^ $past(gpio_out)) & ~$past(q.fsel)) == 8'h00))
        else $error("Port pin does not follow direction and value");

    AST_RESET_FUNC: assert property (@(posedge ref_clk) disable iff (!nrst)
        !cfg_seen_q |-> (q.fsel == sdps_pkg::FSEL_RST))
        else $error("Pin left peripheral function without a write");

    AST_TX_DRIVE: assert property (@(posedge ref_clk) disable iff (!nrst)
        (q.fsel[4] && q.fsel[6]) |=> (!pad_oe_n[4] && !pad_oe_n[6]
            && pad_o[4] == $past(sci0_tx_core) && pad_o[6] == $past(sci1_tx_core)))
        else $error("Transmit pins not driven by serial channels");

    AST_RX_INPUT: assert property (@(posedge ref_clk) disable iff (!nrst)
        (q.fsel[5] && q.fsel[7]) |=> (pad_oe_n[5] && pad_oe_n[7]))
        else $error("Receive pins driven in peripheral use");

    AST_DEC_INPUT: assert property (@(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> (dec_pad_oe_n == ~$past(tmr_oe)))
        else $error("Decoder pin drive not from timer request");

    AST_FSEL_LOAD: assert property (@(posedge ref_clk) disable iff (!nrst)
        cfg_wr |=> (cfg_fsel_q == $past(cfg_fsel) && cfg_dir_q == $past(cfg_dir)))
        else $error("Function select write not taken");

endmodule

`default_nettype wire

// *** tb/sdps_peer.sv ***
// Purpose: Far side model: SPI peer, serial partners, encoder
// Assumes: Link clock idles low; bits sampled on its rising edge
// Notes:   Link clock stands still outside frames

`timescale 1ns/1ps
`default_nettype none

module sdps_peer (
    input  wire logic       dev_master,
    input  wire logic [7:0] fsel,
    input  wire logic [7:0] dir,
    output logic      [7:0] peer_o,
    output logic      [7:0] peer_oe,
    output logic      [7:0] enc_o
);
    // ==========
    // Drive map
    // Never drive a pin the device owns; port-mode inputs are all ours
    assign peer_oe = ((dev_master ? 8'ha9 : 8'hae) & fsel) | (~fsel & ~dir);

    task automatic set_lines(input logic [7:0] lv, input logic [7:0] ev);
        peer_o = lv;
        enc_o  = ev;
    endtask

    // ==========
    // Master role
    task automatic send_byte(input logic [7:0] b, input int nbits, input logic last);
        #3;
        peer_o[3] = 1'b0;
        for (int i = 7; i > 7 - nbits; i--)
        begin
            peer_o[1] = b[i];
            #24;
            peer_o[2] = 1'b1;
            #24;
            peer_o[2] = 1'b0;
        end
        // Stale data after hold so a late sample shows
        peer_o[1] = ~peer_o[1];
        if (last)
        begin
            #24;
            peer_o[3] = 1'b1;
        end
    endtask
endmodule

`default_nettype wire

// *** tb/sdps_pin_mux_tb.sv ***
// Purpose: Self-checking bench for the shared pin multiplexer
// Assumes: Device drive wins over the peer on a shared pad
// Notes:   Undriven pads toggle every cycle so stale values show

`timescale 1ns/1ps
`default_nettype none

module sdps_pin_mux_tb;
    // ==========
    // Signals
    logic       ref_clk = 1'b0;
    logic       nrst = 1'b0;
    logic       flip = 1'b0;
    logic       cfg_wr, spi_master, spi_frame, spi_sclk_core, spi_mosi_core;
    logic       spi_miso_core, sci0_tx_core, sci1_tx_core, spi_link_clk, mosi_l, sclk_l;
    logic [7:0] cfg_fsel, cfg_dir, gpio_out, tmr_out, tmr_oe, pad_i, dec_pad_i;
    logic [7:0] gpio_in, cfg_fsel_q, cfg_dir_q, slv_byte, tmr_in, v, e, x;
    logic [7:0] pad_o, pad_oe_n, dec_pad_o, dec_pad_oe_n, peer_o, peer_oe, enc_o;
    logic       spi_miso_in, spi_mosi_in, spi_sclk_in, spi_ss_n_in, slv_byte_vld;
    logic       sci0_rx, sci1_rx, dec0_phase_a, dec0_phase_b, dec0_index_in;
    logic       dec0_home_in, dec1_phase_a, dec1_phase_b, dec1_index_in, dec1_home_in;
    logic [7:0] exp_q[$];
    int         failures = 0;
    int         comparisons = 0;
    int         seed = 32'h000bf7d1;

    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) flip <= ~flip;

    always_comb
    begin
        for (int i = 0; i < 8; i++)
            pad_i[i] = !pad_oe_n[i] ? pad_o[i] : (peer_oe[i] ? peer_o[i] : flip);
    end
    assign dec_pad_i = (~dec_pad_oe_n & dec_pad_o) | (dec_pad_oe_n & enc_o);
    assign spi_link_clk = pad_i[2];

    sdps_pin_mux u_dut (
        .ref_clk, .nrst, .spi_link_clk, .cfg_wr, .cfg_fsel, .cfg_dir, .gpio_out,
        .gpio_in, .cfg_fsel_q, .cfg_dir_q, .spi_master, .spi_frame, .spi_sclk_core,
        .spi_mosi_core, .spi_miso_core, .spi_miso_in, .spi_mosi_in, .spi_sclk_in,
        .spi_ss_n_in, .slv_byte, .slv_byte_vld, .sci0_tx_core, .sci1_tx_core,
        .sci0_rx, .sci1_rx, .tmr_out, .tmr_oe, .tmr_in, .dec0_phase_a, .dec0_phase_b,
        .dec0_index_in, .dec0_home_in, .dec1_phase_a, .dec1_phase_b, .dec1_index_in,
        .dec1_home_in, .pad_i, .pad_o, .pad_oe_n, .dec_pad_i, .dec_pad_o, .dec_pad_oe_n
    );

    sdps_peer u_peer (
        .dev_master(spi_master),
        .fsel(cfg_fsel_q),
        .dir(cfg_dir_q),
        .peer_o,
        .peer_oe,
        .enc_o
    );

    // ==========
    // Checking
    task automatic chk(input string what, input logic [7:0] ex, input logic [7:0] got);
        comparisons++;
        if (got !== ex)
        begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, ex, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        if (slv_byte_vld === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("extra byte", 8'h00, slv_byte);
            else
                chk("slave byte", exp_q.pop_front(), slv_byte);
        end
    end

    // Pad values read before this edge lands, so no race with drivers
    always @(posedge ref_clk)
    begin
        if (nrst && spi_master && spi_frame)
        begin
            if (sclk_l && !pad_o[2])
                chk("mosi bit", {7'h00, spi_mosi_core}, {7'h00, pad_o[1]});
            else if (pad_o[1] !== mosi_l)
                chk("mosi hold", {7'h00, mosi_l}, {7'h00, pad_o[1]});
        end
        mosi_l = pad_o[1];
        sclk_l = pad_o[2];
    end

    initial
    begin
        #100000;
        failures++;
        $display("watchdog expired");
        wrap_up();
    end

    // ==========
    // Tests
    initial
    begin
        {cfg_wr, spi_master, spi_frame, spi_sclk_core, spi_mosi_core} = 5'h00;
        {spi_miso_core, sci0_tx_core, sci1_tx_core} = 3'h0;
        {cfg_fsel, cfg_dir, gpio_out, tmr_out, tmr_oe} = 40'h0;
        u_peer.set_lines(8'h08, 8'h00);
        cyc(3);
        chk("reset oe_n", 8'hff, pad_oe_n);
        chk("reset dec oe_n", 8'hff, dec_pad_oe_n);
        chk("reset fsel", 8'hff, cfg_fsel_q);
        chk("reset dir", 8'h00, cfg_dir_q);
        cyc(3);
        nrst = 1'b1;
        cyc(1);
        chk("early slave oe_n", 8'haf, pad_oe_n);
        cyc(3);
        chk("idle slave oe_n", 8'haf, pad_oe_n);
        $display("test reset done");

        for (int k = 0; k < 4; k++)
        begin
            v = 8'($random(seed));
            spi_miso_core = v[0];
            if (k != 2)
                exp_q.push_back(v);
            u_peer.send_byte(v, (k == 2) ? 5 : 8, k > 1);
            cyc(1);
            if (k < 2)
            begin
                chk("selected oe_n", 8'hae, pad_oe_n);
                chk("slave out", {7'h00, v[0]}, {7'h00, pad_o[0]});
            end
            else
            begin
                cyc(4);
                chk("released oe_n", 8'haf, pad_oe_n);
            end
        end
        cyc(8);
        chk("bytes left", 8'h00, 8'(exp_q.size()));
        $display("test slave done");

        spi_master = 1'b1;
        cyc(4);
        spi_frame = 1'b1;
        for (int k = 0; k < 16; k++)
        begin
            v = 8'($random(seed));
            e = 8'($random(seed));
            u_peer.set_lines(v | 8'h08, e);
            {tmr_oe, tmr_out} = 16'($random(seed));
            {sci0_tx_core, sci1_tx_core, spi_miso_core} = 3'($random(seed));
            spi_sclk_core = ~spi_sclk_core;
            if (!spi_sclk_core)
                spi_mosi_core = v[1];
            cyc(1);
            chk("master oe_n", 8'ha9, pad_oe_n);
            x = {1'b0, sci1_tx_core, 1'b0, sci0_tx_core, 1'b0, spi_sclk_core, 2'b00};
            chk("tx and clock", x, pad_o & 8'h54);
            chk("timer oe_n", ~tmr_oe, dec_pad_oe_n);
            chk("timer out", tmr_out, dec_pad_o);
            cyc(3);
            x = (tmr_oe & tmr_out) | (~tmr_oe & e);
            chk("timer in", x, tmr_in);
            chk("decoders", x, {dec1_home_in, dec1_index_in, dec1_phase_b, dec1_phase_a,
                dec0_home_in, dec0_index_in, dec0_phase_b, dec0_phase_a});
            chk("rx miso ss", {2'h0, spi_sclk_core, spi_mosi_core, v[7], v[5], v[0], 1'b1},
                {2'h0, spi_sclk_in, spi_mosi_in, sci1_rx, sci0_rx, spi_miso_in,
                spi_ss_n_in});
        end
        spi_frame = 1'b0;
        cyc(2);
        spi_master = 1'b0;
        $display("test master done");

        for (int k = 0; k < 4; k++)
        begin
            v = 8'($random(seed));
            e = 8'($random(seed));
            gpio_out = 8'($random(seed));
            cfg_fsel = 8'h00;
            cfg_dir = e;
            cfg_wr = 1'b1;
            cyc(1);
            cfg_wr = 1'b0;
            u_peer.set_lines(v, 8'h00);
            cyc(4);
            chk("port fsel", 8'h00, cfg_fsel_q);
            chk("port dir", e, cfg_dir_q);
            chk("port oe_n", ~e, pad_oe_n);
            chk("port out", e & gpio_out, pad_o & e);
            chk("port in", (e & gpio_out) | (~e & v), gpio_in);
            chk("port idle", 8'h07, {5'h00, sci1_rx, sci0_rx, spi_ss_n_in});
        end
        u_peer.set_lines(8'h08, 8'h00);
        cfg_fsel = 8'hff;
        cfg_wr = 1'b1;
        cyc(1);
        cfg_wr = 1'b0;
        cyc(3);
        chk("restored oe_n", 8'haf, pad_oe_n);
        $display("test port done");
        wrap_up();
    end
endmodule

`default_nettype wire
